/* File: rtl/bcdalu_top.sv */
// AXI4-Lite wrapper holding the working register, flags, bank select and data memory.
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`default_nettype none

module bcdalu_top
    import bcdalu_pkg::*;
(
    // Clock and reset.
    input  wire logic        REF_CLK_I,
    input  wire logic        RESET_I,
    // AXI4-Lite write address channel.
    input  wire logic [7:0]  S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    // AXI4-Lite write data channel.
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    // AXI4-Lite write response channel.
    output logic [1:0]       S_AXI_BRESP_O,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    // AXI4-Lite read address channel.
    input  wire logic [7:0]  S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    // AXI4-Lite read data channel.
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I
);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus channel state.
    logic        aw_v_r,  aw_v_nxt;     // Write address held.
    logic [7:0]  aw_a_r,  aw_a_nxt;     // Held write address.
    logic        w_v_r,   w_v_nxt;      // Write data held.
    logic [31:0] w_d_r,   w_d_nxt;      // Held write data.
    logic [3:0]  w_s_r,   w_s_nxt;      // Held byte strobes.
    logic        b_v_r,   b_v_nxt;      // Write response pending.
    logic [1:0]  b_r_r,   b_r_nxt;      // Write response code.
    logic        r_v_r,   r_v_nxt;      // Read data pending.
    logic [31:0] r_d_r,   r_d_nxt;      // Read data.
    logic [1:0]  r_r_r,   r_r_nxt;      // Read response code.

    // Processor state.
    logic [7:0]  work_r,  work_nxt;     // Working register.
    logic [3:0]  bank_r,  bank_nxt;     // Bank select register.
    logic [4:0]  stat_r,  stat_nxt;     // Status flags.
    logic [11:0] ptr_r,   ptr_nxt;      // Data window pointer.
    logic        ill_r,   ill_nxt;      // Sticky unknown instruction flag.
    logic [7:0]  last_r,  last_nxt;     // Result of the last executed instruction.

    // Data memory, sixteen banks of 256 bytes.
    logic [7:0]  mem [0:4095];
    logic        mem_we;                // Memory write this cycle.
    logic [11:0] mem_wa;                // Memory write address.
    logic [7:0]  mem_wd;                // Memory write data.

    // Execution signals.
    logic        do_wr;                 // Both write halves held, commit now.
    logic [15:0] instr;                 // Instruction word from the strobed lanes.
    bcdalu_op_e  op;                    // Decoded operation.
    logic        exec;                  // An instruction executes this cycle.
    logic [3:0]  eff_bank;              // Bank used by the decrement.
    logic [11:0] file_addr;             // Physical file register address.
    logic [7:0]  alu_res;               // Arithmetic result.
    logic [4:0]  alu_flags;             // Arithmetic flags.
    logic [31:0] rd_word;               // Read mux output.

    ////////////////////////////////////////////////////////////////////////////////
    // Ready drops while its half or a response is held: one write at a time.
    assign S_AXI_AWREADY_O = !aw_v_r && !b_v_r;
    assign S_AXI_WREADY_O  = !w_v_r && !b_v_r;
    assign S_AXI_ARREADY_O = !r_v_r;
    assign S_AXI_BVALID_O  = b_v_r;
    assign S_AXI_BRESP_O   = b_r_r;
    assign S_AXI_RVALID_O  = r_v_r;
    assign S_AXI_RDATA_O   = r_d_r;
    assign S_AXI_RRESP_O   = r_r_r;

    assign do_wr = aw_v_r && w_v_r;

    // Instruction word decode; missing lanes read as zero.
    always_comb begin
        instr = {(w_s_r[1] ? w_d_r[15:8] : 8'h00), (w_s_r[0] ? w_d_r[7:0] : 8'h00)};
        op    = bcdalu_decode(instr);
        exec  = do_wr && (aw_a_r == OFF_INSTR) && (w_s_r[1:0] != 2'b00);
        // Access bank mapping ignores the bank select register.
        if (instr[ACC_BIT]) begin
            eff_bank = bank_r;
        end else begin
            eff_bank = (instr[7:0] < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK;
        end
        file_addr = {eff_bank, instr[7:0]};
    end

    // Arithmetic unit, only meaningful while exec is high.
    bcdalu_core u_core (
        .op_i     (exec ? op : OP_NONE),
        .work_i   (work_r),
        .file_i   (mem[file_addr]),
        .flags_i  (stat_r),
        .result_o (alu_res),
        .flags_o  (alu_flags)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Write path: capture each half in either order, commit once both are held.
    always_comb begin
        aw_v_nxt = aw_v_r;
        aw_a_nxt = aw_a_r;
        w_v_nxt  = w_v_r;
        w_d_nxt  = w_d_r;
        w_s_nxt  = w_s_r;
        b_v_nxt  = b_v_r;
        b_r_nxt  = b_r_r;
        if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            // Address taken, forced to word alignment.
            aw_v_nxt = 1'b1;
            aw_a_nxt = {S_AXI_AWADDR_I[7:2], 2'b00};
        end
        if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            // Data taken.
            w_v_nxt = 1'b1;
            w_d_nxt = S_AXI_WDATA_I;
            w_s_nxt = S_AXI_WSTRB_I;
        end
        if (do_wr) begin
            // Commit, free both halves and raise the response.
            aw_v_nxt = 1'b0;
            w_v_nxt  = 1'b0;
            b_v_nxt  = 1'b1;
            b_r_nxt  = bcdalu_mapped(aw_a_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (b_v_r && S_AXI_BREADY_I) begin
            // Response accepted.
            b_v_nxt = 1'b0;
        end
    end

    // Register the write path.
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            aw_v_r <= 1'b0;
            aw_a_r <= 8'h00;
            w_v_r  <= 1'b0;
            w_d_r  <= 32'h0000_0000;
            w_s_r  <= 4'h0;
            b_v_r  <= 1'b0;
            b_r_r  <= RESP_OKAY;
        end else begin
            aw_v_r <= aw_v_nxt;
            aw_a_r <= aw_a_nxt;
            w_v_r  <= w_v_nxt;
            w_d_r  <= w_d_nxt;
            w_s_r  <= w_s_nxt;
            b_v_r  <= b_v_nxt;
            b_r_r  <= b_r_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Processor state and memory write selection. Each instruction finishes in the
    // single cycle in which its bus write commits.
    always_comb begin
        work_nxt = work_r;
        bank_nxt = bank_r;
        stat_nxt = stat_r;
        ptr_nxt  = ptr_r;
        ill_nxt  = ill_r;
        last_nxt = last_r;
        mem_we   = 1'b0;
        mem_wa   = file_addr;
        mem_wd   = alu_res;
        if (exec) begin
            unique case (op)
                OP_ADJ: begin
                    // Adjusted value goes back to the working register.
                    work_nxt = alu_res;
                    stat_nxt = alu_flags;
                    last_nxt = alu_res;
                end
                OP_DEC: begin
                    // Destination bit picks the working register or the file.
                    if (instr[DEST_BIT]) begin
                        mem_we = 1'b1;
                    end else begin
                        work_nxt = alu_res;
                    end
                    stat_nxt = alu_flags;
                    last_nxt = alu_res;
                end
                OP_NONE: begin
                    // Unknown word is recorded and otherwise ignored.
                    ill_nxt = 1'b1;
                end
            endcase
        end else if (do_wr) begin
            // Plain writes use lane zero; the pointer uses two lanes.
            unique case (aw_a_r)
                OFF_WORK: begin
                    if (w_s_r[0]) work_nxt = w_d_r[7:0];
                end
                OFF_BANK: begin
                    if (w_s_r[0]) bank_nxt = w_d_r[3:0];
                end
                OFF_STAT: begin
                    if (w_s_r[0]) stat_nxt = w_d_r[4:0];
                end
                OFF_PTR: begin
                    if (w_s_r[0]) ptr_nxt[7:0] = w_d_r[7:0];
                    if (w_s_r[1]) ptr_nxt[11:8] = w_d_r[11:8];
                end
                OFF_DATA: begin
                    // Window write goes straight into the memory.
                    mem_we = w_s_r[0];
                    mem_wa = ptr_r;
                    mem_wd = w_d_r[7:0];
                end
                OFF_INFO: begin
                    // Write one clears the sticky error bit.
                    if (w_s_r[0] && w_d_r[INFO_ILL]) ill_nxt = 1'b0;
                end
                default: begin
                    // Unmapped or instruction write with no lanes: no effect.
                    ill_nxt = ill_r;
                end
            endcase
        end
    end

    // Register the processor state.
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            work_r <= WORK_RST;
            bank_r <= BANK_RST;
            stat_r <= STAT_RST;
            ptr_r  <= PTR_RST;
            ill_r  <= 1'b0;
            last_r <= LAST_RST;
        end else begin
            work_r <= work_nxt;
            bank_r <= bank_nxt;
            stat_r <= stat_nxt;
            ptr_r  <= ptr_nxt;
            ill_r  <= ill_nxt;
            last_r <= last_nxt;
        end
    end

    // Memory has no reset; software must initialise any byte it relies on.
    always_ff @(posedge REF_CLK_I) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux; the value is sampled at the address handshake.
    always_comb begin
        unique case ({S_AXI_ARADDR_I[7:2], 2'b00})
            OFF_WORK: rd_word = {24'h000000, work_r};
            OFF_BANK: rd_word = {28'h0000000, bank_r};
            OFF_STAT: rd_word = {27'h0000000, stat_r};
            OFF_PTR:  rd_word = {20'h00000, ptr_r};
            OFF_DATA: rd_word = {24'h000000, mem[ptr_r]};
            OFF_INFO: rd_word = {16'h0000, last_r, 7'h00, ill_r};
            default:  rd_word = 32'h0000_0000;
        endcase
    end

    // Read path: one read in flight, answered one edge after the address.
    always_comb begin
        r_v_nxt = r_v_r;
        r_d_nxt = r_d_r;
        r_r_nxt = r_r_r;
        if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            r_v_nxt = 1'b1;
            r_d_nxt = rd_word;
            r_r_nxt = bcdalu_mapped({S_AXI_ARADDR_I[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
        end else if (r_v_r && S_AXI_RREADY_I) begin
            r_v_nxt = 1'b0;
        end
    end

    // Register the read path.
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            r_v_r <= 1'b0;
            r_d_r <= 32'h0000_0000;
            r_r_r <= RESP_OKAY;
        end else begin
            r_v_r <= r_v_nxt;
            r_d_r <= r_d_nxt;
            r_r_r <= r_r_nxt;
        end
    end

endmodule : bcdalu_top

`default_nettype wire

/* File: rtl/bcdalu_pkg.sv */
// Constants, types and decode helpers for the decimal adjust and decrement unit.
// Operation
// - Decimal adjust adds six per nibble above nine
// - Decrement subtracts one from addressed file register
// - Destination bit zero selects working register, one file
// - Access bit zero uses access bank, one banked
`default_nettype none

package bcdalu_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the AXI4-Lite port.
    localparam logic [7:0] OFF_INSTR = 8'h00;  // Instruction word, a write executes it.
    localparam logic [7:0] OFF_WORK  = 8'h04;  // Working register.
    localparam logic [7:0] OFF_BANK  = 8'h08;  // Bank select register.
    localparam logic [7:0] OFF_STAT  = 8'h0c;  // Status flags.
    localparam logic [7:0] OFF_PTR   = 8'h10;  // Data memory pointer for the window.
    localparam logic [7:0] OFF_DATA  = 8'h14;  // Data memory window.
    localparam logic [7:0] OFF_INFO  = 8'h18;  // Sticky error bit and last result.

    // Reset values.
    localparam logic [7:0]  WORK_RST = 8'h00;
    localparam logic [3:0]  BANK_RST = 4'h0;
    localparam logic [4:0]  STAT_RST = 5'h00;
    localparam logic [11:0] PTR_RST  = 12'h000;
    localparam logic [7:0]  LAST_RST = 8'h00;

    // Status flag bit positions.
    localparam int FLG_C  = 0;
    localparam int FLG_HC = 1;
    localparam int FLG_Z  = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_N  = 4;

    // Info register field positions.
    localparam int INFO_ILL  = 0;
    localparam int INFO_LAST = 8;

    // Instruction encodings and operand field positions.
    localparam logic [15:0] ADJ_CODE  = 16'h0007;
    localparam logic [15:0] DEC_MASK  = 16'hfc00;
    localparam logic [15:0] DEC_CODE  = 16'h0400;
    localparam int          DEST_BIT  = 9;
    localparam int          ACC_BIT   = 8;

    // Arithmetic constants.
    localparam logic [3:0] BCD_LIMIT = 4'h9;
    localparam logic [3:0] BCD_FIX   = 4'h6;
    localparam logic [7:0] DEC_STEP  = 8'h01;

    // Access bank mapping: low half from one bank, high half from another.
    localparam logic [7:0] ACC_SPLIT   = 8'h80;
    localparam logic [3:0] ACC_LO_BANK = 4'h0;
    localparam logic [3:0] ACC_HI_BANK = 4'hf;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Decoded operation, one-hot.
    typedef enum logic [2:0] {
        OP_NONE = 3'b001,
        OP_ADJ  = 3'b010,
        OP_DEC  = 3'b100
    } bcdalu_op_e;

    // Classify a 16-bit instruction word.
    function automatic bcdalu_op_e bcdalu_decode(input logic [15:0] word);
        if (word == ADJ_CODE) return OP_ADJ;
        if ((word & DEC_MASK) == DEC_CODE) return OP_DEC;
        return OP_NONE;
    endfunction : bcdalu_decode

    // True for any aligned address in the contiguous map.
    function automatic logic bcdalu_mapped(input logic [7:0] addr);
        return (addr[1:0] == 2'b00) && (addr <= OFF_INFO);
    endfunction : bcdalu_mapped

endpackage : bcdalu_pkg

`default_nettype wire

/* File: rtl/bcdalu_core.sv */
// Combinational arithmetic for the decimal adjust and the decrement instructions.
`default_nettype none

module bcdalu_core
    import bcdalu_pkg::*;
(
    // Operation select.
    input  wire bcdalu_op_e  op_i,
    // Operands.
    input  wire logic [7:0]  work_i,
    input  wire logic [7:0]  file_i,
    input  wire logic [4:0]  flags_i,
    // Results.
    output logic      [7:0]  result_o,
    output logic      [4:0]  flags_o
);

    ////////////////////////////////////////////////////////////////////////////////
    logic       lo_fix;   // Low nibble needs correction.
    logic       hi_fix;   // High nibble needs correction.
    logic [8:0] stage1;   // Value after the low correction, with carry.
    logic [8:0] stage2;   // Value after the high correction, with carry.
    logic [8:0] diff;     // Decrement result with borrow.

    // Both datapaths are computed every cycle; the op select picks the outcome.
    always_comb begin
        // The low correction can carry into the high nibble, so the high test
        // looks at the already corrected value.
        lo_fix  = (work_i[3:0] > BCD_LIMIT) || flags_i[FLG_HC];
        stage1  = {1'b0, work_i} + {5'h00, (lo_fix ? BCD_FIX : 4'h0)};
        hi_fix  = (stage1[7:4] > BCD_LIMIT) || flags_i[FLG_C] || stage1[8];
        stage2  = {1'b0, stage1[7:0]} + {1'b0, (hi_fix ? BCD_FIX : 4'h0), 4'h0};
        diff    = {1'b0, file_i} - {1'b0, DEC_STEP};
        result_o = work_i;
        flags_o  = flags_i;
        unique case (op_i)
            OP_ADJ: begin
                // Only the carry moves; a carry set before stays set.
                result_o       = stage2[7:0];
                flags_o[FLG_C] = flags_i[FLG_C] | stage1[8] | stage2[8];
            end
            OP_DEC: begin
                // Carry flags mean no borrow, as for any subtraction.
                result_o        = diff[7:0];
                flags_o[FLG_C]  = ~diff[8];
                flags_o[FLG_HC] = (file_i[3:0] != 4'h0);
                flags_o[FLG_Z]  = (diff[7:0] == 8'h00);
                flags_o[FLG_N]  = diff[7];
                flags_o[FLG_OV] = (file_i[7] ^ DEC_STEP[7]) & (diff[7] ^ file_i[7]);
            end
            OP_NONE: begin
                // Unknown word: the defaults above stand.
            end
        endcase
    end

endmodule : bcdalu_core

`default_nettype wire

/* File: tb/bcdalu_top_asserts.sv */
// Concurrent checks on the register bus of the decimal adjust and decrement unit.
`default_nettype none

module bcdalu_top_asserts
    import bcdalu_pkg::*;
(
    // Clock and reset.
    input wire logic        REF_CLK_I,
    input wire logic        RESET_I,
    // Write channels.
    input wire logic        S_AXI_AWVALID_I,
    input wire logic        S_AXI_AWREADY_O,
    input wire logic        S_AXI_WVALID_I,
    input wire logic        S_AXI_WREADY_O,
    input wire logic [1:0]  S_AXI_BRESP_O,
    input wire logic        S_AXI_BVALID_O,
    input wire logic        S_AXI_BREADY_I,
    // Read channels.
    input wire logic [7:0]  S_AXI_ARADDR_I,
    input wire logic        S_AXI_ARVALID_I,
    input wire logic        S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic [1:0]  S_AXI_RRESP_O,
    input wire logic        S_AXI_RVALID_O,
    input wire logic        S_AXI_RREADY_I
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RESET_I);

    // Handshakes; the write one needs both halves at one edge.
    wire ar_take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    wire wr_take = S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;

    // An instruction commits one cycle after it is taken.
    property p_b_lat; wr_take |=> !S_AXI_BVALID_O ##1 S_AXI_BVALID_O; endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    property p_r_lat; ar_take |=> S_AXI_RVALID_O; endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_b_hold; S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold;
        S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_b_drop; S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O; endproperty
    a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
    property p_r_drop; S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O; endproperty
    a_r_drop: assert property (p_r_drop) else $error("read answer repeated");
    // No new write is taken while its answer waits.
    property p_busy; S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O; endproperty
    a_busy: assert property (p_busy) else $error("request taken while busy");
    // Holes in the map answer with an error and zero data.
    property p_hole;
        ar_take && S_AXI_ARADDR_I[7:2] > 6'h06 |=>
            S_AXI_RRESP_O == RESP_SLVERR && S_AXI_RDATA_O == 32'h0;
    endproperty
    a_hole: assert property (p_hole) else $error("unmapped read not refused");
    // Registers are at most sixteen bits wide.
    property p_upper; S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:16] == 16'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");

    c_write: cover property (wr_take ##2 S_AXI_BVALID_O);
    c_read: cover property (ar_take ##1 S_AXI_RVALID_O);
    c_hole: cover property (S_AXI_RVALID_O && S_AXI_RRESP_O == RESP_SLVERR);
endmodule : bcdalu_top_asserts

bind bcdalu_top bcdalu_top_asserts u_chk (.*);

`default_nettype wire

/* File: tb/bcdalu_top_bench.sv */
// Self-checking bench for the decimal adjust and decrement unit.
`default_nettype none

module bcdalu_top_bench
    import bcdalu_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;

    // Bus master side; every input starts idle.
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic [7:0]  araddr = 8'h00;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    // Slave answers.
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          miscompares = 0;
    int          n_tests = 0;

    bcdalu_top DUT (
        .REF_CLK_I(clk), .RESET_I(rst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
        .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
        .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready)
    );

    // 50 MHz clock.
    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Counts one comparison and reports a mismatch at once.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One write; each half is released at the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic aw_ok, w_ok;
        @(posedge clk);
        {awaddr, wdata, wstrb} <= {a, d, s};
        {awvalid, wvalid, bready} <= 3'b111;
        {aw_ok, w_ok} = 2'b00;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    // Full-word write that must be accepted.
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, 4'hf, r);
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask : w

    // One read; rready stays high until the answer is seen.
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    // Read a register and compare it with the expected word.
    task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(what, exp, d);
    endtask : rc

    // Place one byte in data memory through the pointer window.
    task automatic mw(input logic [11:0] a, input logic [7:0] v);
        w(OFF_PTR, {20'h0, a});
        w(OFF_DATA, {24'h0, v});
    endtask : mw

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and refusal of holes in the map.
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        rc("work", OFF_WORK, 32'h0);
        rc("bank", OFF_BANK, 32'h0);
        rc("stat", OFF_STAT, 32'h0);
        rc("ptr", OFF_PTR, 32'h0);
        rc("info", OFF_INFO, 32'h0);
        rd(8'h1c, d, r);
        chk("hole rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        wr(8'h1c, 32'h0, 4'hf, r);
        chk("hole bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        $display("t_reset done");
    endtask : t_reset

    // Decimal adjust over nibble, carry and digit carry cases.
    task automatic t_adjust();
        logic [7:0] cw [6] = '{8'ha5, 8'hce, 8'h09, 8'h45, 8'h99, 8'h28};
        logic [4:0] cs [6] = '{5'h00, 5'h00, 5'h02, 5'h15, 5'h00, 5'h1f};
        logic [8:0] t;
        logic [4:0] s;
        for (int i = 0; i < 6; i++) begin
            t = {1'b0, cw[i]};
            s = cs[i];
            if (t[3:0] > 4'h9 || s[FLG_HC]) t = t + 9'h006;
            if (t[7:4] > 4'h9 || s[FLG_C] || t[8]) t = t + 9'h060;
            s[FLG_C] = s[FLG_C] | t[8];
            w(OFF_WORK, {24'h0, cw[i]});
            w(OFF_STAT, {27'h0, cs[i]});
            w(OFF_INSTR, {16'h0, ADJ_CODE});
            rc("adjust work", OFF_WORK, {24'h0, t[7:0]});
            rc("adjust stat", OFF_STAT, {27'h0, s});
        end
        $display("t_adjust done");
    endtask : t_adjust

    // Decrement across both destinations and both banking modes; a decoy
    // byte in the wrong bank shows a wrong address choice.
    task automatic t_dec();
        logic [7:0]  cf [4] = '{8'h20, 8'h35, 8'h80, 8'h90};
        logic [7:0]  cv [4] = '{8'h01, 8'h00, 8'h80, 8'h10};
        logic [1:0]  cda [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
        logic [11:0] acc, hit, miss;
        logic [7:0]  res;
        logic [4:0]  e;
        w(OFF_BANK, 32'h3);
        for (int i = 0; i < 4; i++) begin
            acc = (cf[i] < 8'h80) ? {4'h0, cf[i]} : {4'hf, cf[i]};
            hit = cda[i][0] ? {4'h3, cf[i]} : acc;
            miss = cda[i][0] ? acc : {4'h3, cf[i]};
            mw(miss, cv[i] ^ 8'h5a);
            mw(hit, cv[i]);
            w(OFF_WORK, 32'hc3);
            w(OFF_INSTR, {22'h1, cda[i], cf[i]});
            res = cv[i] - 8'h01;
            e = 5'h00;
            e[FLG_C] = cv[i] != 8'h00;
            e[FLG_HC] = cv[i][3:0] != 4'h0;
            e[FLG_Z] = res == 8'h00;
            e[FLG_N] = res[7];
            e[FLG_OV] = cv[i] == 8'h80;
            rc("dec work", OFF_WORK, {24'h0, cda[i][1] ? 8'hc3 : res});
            w(OFF_PTR, {20'h0, hit});
            rc("dec file", OFF_DATA, {24'h0, cda[i][1] ? res : cv[i]});
            rc("dec stat", OFF_STAT, {27'h0, e});
            w(OFF_PTR, {20'h0, miss});
            rc("dec other bank", OFF_DATA, {24'h0, cv[i] ^ 8'h5a});
        end
        $display("t_dec done");
    endtask : t_dec

    // Empty lanes and unknown words leave the working register alone.
    task automatic t_other();
        logic [1:0]  r;
        w(OFF_WORK, 32'h5a);
        wr(OFF_INSTR, {16'h0, ADJ_CODE}, 4'h0, r);
        chk("no lane bresp", {30'h0, RESP_OKAY}, {30'h0, r});
        w(OFF_INSTR, 32'h1234);
        rc("work kept", OFF_WORK, 32'h5a);
        rc("instr reads zero", OFF_INSTR, 32'h0);
        rc("unknown flag", OFF_INFO, 32'h0f01);
        w(OFF_INFO, 32'h1);
        rc("unknown clear", OFF_INFO, 32'h0f00);
        $display("t_other done");
    endtask : t_other

    ////////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    // Main sequence after sixteen cycles of reset.
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_adjust();
        t_dec();
        t_other();
        report_and_stop();
    end

    // Watchdog, far beyond the test length.
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        $display("[ERR] watchdog expected finish seen timeout");
        report_and_stop();
    end
endmodule : bcdalu_top_bench

`default_nettype wire
